// file: bench/asr_ctrl_props.sv
`timescale 1ns/1ps
module asr_ctrl_props (
  input wire clk_i,
  input wire rst_b_i,
  input wire [11:0] mem_addr_o,
  input wire mem_cs_b_o,
  input wire mem_we_b_o,
  input wire mem_oe_b_o,
  input wire mem_dq_oe_b_o,
  input wire done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_strobe_sel: assert property ($fell(mem_we_b_o) |-> !mem_cs_b_o)
    else $error("strobe low without select");
  chk_write_drive: assert property (!mem_we_b_o |-> !mem_dq_oe_b_o)
    else $error("data not driven in write");
  chk_addr_stable: assert property ($fell(mem_cs_b_o) |-> $stable(mem_addr_o))
    else $error("address moved at select fall");
  chk_read_wait: assert property ($fell(mem_oe_b_o) |-> !done_o[*4] ##1 done_o)
    else $error("read data taken at wrong time");
  chk_we_end: assert property ($rose(mem_we_b_o) && !mem_cs_b_o |=> mem_cs_b_o)
    else $error("select held after strobe end");
  chk_cs_end: assert property ($rose(mem_cs_b_o) && !mem_we_b_o |=> mem_we_b_o)
    else $error("strobe held after select end");
  chk_read_start: assert property ($fell(mem_oe_b_o) |-> $fell(mem_cs_b_o))
    else $error("read not started by select");
  chk_read_ctl: assert property (!mem_oe_b_o |-> mem_we_b_o && !mem_cs_b_o)
    else $error("bad controls in read");
endmodule // asr_ctrl_props
bind asr_ctrl asr_ctrl_props u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .mem_addr_o(mem_addr_o),
  .mem_cs_b_o(mem_cs_b_o), .mem_we_b_o(mem_we_b_o), .mem_oe_b_o(mem_oe_b_o),
  .mem_dq_oe_b_o(mem_dq_oe_b_o), .done_o(done_o));

// file: bench/asr_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "asr_defines.vh"
module asr_ctrl_tb_top;
  reg clk, rst_b, req, we, ce;
  reg [11:0] addr;
  reg [3:0] wd, d;
  reg [3:0] exp_mem [0:4095];
  wire busy, done, cs_b, we_b, oe_b, dq_oe_b;
  wire [3:0] rd, ctl_dq, ram_q, dq;
  wire [11:0] ma;
  integer seed, mismatches, num_checks, i;
  assign dq = !dq_oe_b ? ctl_dq : ram_q;
  asr_ctrl uut (.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .we_i(we), .cs_end_i(ce),
    .addr_i(addr), .wdata_i(wd), .busy_o(busy), .done_o(done), .rdata_o(rd),
    .mem_addr_o(ma), .mem_cs_b_o(cs_b), .mem_we_b_o(we_b), .mem_oe_b_o(oe_b),
    .mem_dq_i(dq), .mem_dq_o(ctl_dq), .mem_dq_oe_b_o(dq_oe_b));
  asr_sram_model ram (.addr_i(ma), .cs_b_i(cs_b), .we_b_i(we_b), .oe_b_i(oe_b),
    .d_i(dq), .q_o(ram_q));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task cmp(input [3:0] e, input [3:0] s);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH rdata exp %h got %h", e, s);
      end
    end
  endtask
  task cmp_lat(input [7:0] e, input [7:0] s);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH latency exp %0d got %0d", e, s);
      end
    end
  endtask
  // falling edges from the taking edge until done is seen
  function integer exp_lat(input w);
    begin
      exp_lat = w ? `ASR_WP_CYC + 2 : `ASR_AA_CYC + 5;
    end
  endfunction
  // one transfer; waits on busy with a bound
  task op(input w, input c, input [11:0] a, input [3:0] v);
    integer n;
    integer lat;
    begin
      @(negedge clk) {req, we, ce, addr, wd} = {1'b1, w, c, a, v};
      n = 0;
      lat = 0;
      while ((n == 0 || busy !== 1'b0) && n < 20) begin
        @(negedge clk) n = n + 1;
        req = 0;
        if (done === 1'b1) lat = n;
      end
      if (busy !== 1'b0) begin
        mismatches = mismatches + 1;
        $display("MISMATCH busy exp 0 got %b", busy);
      end
      cmp_lat(exp_lat(w), lat);
      if (w) exp_mem[a] = v;
    end
  endtask
  initial begin
    #1000000 mismatches = mismatches + 1;
    stop_test;
  end
  // ****
  // random writes and read-back, boundary addresses first
  // ****
  initial begin
    {req, we, ce, addr, wd} = 0;
    rst_b = 0;
    seed = 32'h0c25c2ab;
    mismatches = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    @(negedge clk) rst_b = 1;
    for (i = 0; i < 60; i = i + 1) begin
      addr = (i < 2) ? {12{i[0]}} : $random(seed);
      d = $random(seed);
      op(1, $random(seed), addr, d);
      op(1, i[1], addr, ~d);
      op(0, 0, addr, 4'h0);
      cmp(exp_mem[addr], rd);
    end
    stop_test;
  end
endmodule // asr_ctrl_tb_top

// file: bench/asr_sram_model.sv
`timescale 1ns/1ps
module asr_sram_model (
  input wire [11:0] addr_i,
  input wire cs_b_i,
  input wire we_b_i,
  input wire oe_b_i,
  input wire [3:0] d_i,
  output wire [3:0] q_o
);
  reg [3:0] mem [0:4095];
  always @(posedge we_b_i) if (!cs_b_i) mem[addr_i] <= d_i;
  always @(posedge cs_b_i) if (!we_b_i) mem[addr_i] <= d_i;
  // floated pins show inverse data, never a lucky match
  assign q_o = (!cs_b_i && we_b_i && !oe_b_i) ? mem[addr_i] : ~mem[addr_i];
endmodule // asr_sram_model

// file: logic/asr_ctrl.v
`timescale 1ns/1ps
`include "asr_defines.vh"
module asr_ctrl #(
  parameter AW = `ASR_AW,
  parameter DW = `ASR_DW,
  parameter AA_CYC = `ASR_AA_CYC,
  parameter WP_CYC = `ASR_WP_CYC,
  parameter HZ_CYC = `ASR_HZ_CYC
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire req_i,
  input wire we_i,
  input wire cs_end_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg busy_o,
  output reg done_o,
  output reg [DW-1:0] rdata_o,
  output reg [AW-1:0] mem_addr_o,
  output reg mem_cs_b_o,
  output reg mem_we_b_o,
  output reg mem_oe_b_o,
  input wire [DW-1:0] mem_dq_i,
  output reg [DW-1:0] mem_dq_o,
  output reg mem_dq_oe_b_o
);
  // ****************************************
  // states
  // ****************************************
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RSEL = 6'h02;
  localparam [5:0] S_RWAIT = 6'h04;
  localparam [5:0] S_WSEL = 6'h08;
  localparam [5:0] S_WPUL = 6'h10;
  localparam [5:0] S_REC = 6'h20;
  localparam [31:0] AA_W = AA_CYC;
  localparam [31:0] WP_W = WP_CYC;
  localparam [31:0] HZ_W = HZ_CYC;
  // counts cut to the counter on purpose; access waits above 13 cycles need a wider counter
  localparam [3:0] AA_N = AA_W[3:0];
  localparam [3:0] WP_N = WP_W[3:0];
  localparam [3:0] HZ_N = HZ_W[3:0];

  reg [5:0] st_q;
  reg [5:0] st_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  reg csend_q;
  reg csend_d;
  reg busy_d;
  reg done_d;
  reg [DW-1:0] rdata_d;
  reg [AW-1:0] addr_d;
  reg cs_b_d;
  reg we_b_d;
  reg oe_b_d;
  reg [DW-1:0] dq_d;
  reg dq_oe_b_d;
  wire [DW-1:0] dq_sync;

  // pins from the memory cross into our clock before anything looks at them
  asr_sync #(
    .W(DW)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(mem_dq_i),
    .q_o(dq_sync)
  );
  // ****************************************
  // sequencer
  // ****************************************
  always @* begin
    // every flop holds unless its state says otherwise; done is a one-cycle pulse
    st_d = st_q;
    cnt_d = cnt_q;
    csend_d = csend_q;
    busy_d = busy_o;
    done_d = 1'b0;
    rdata_d = rdata_o;
    addr_d = mem_addr_o;
    cs_b_d = mem_cs_b_o;
    we_b_d = mem_we_b_o;
    oe_b_d = mem_oe_b_o;
    dq_d = mem_dq_o;
    dq_oe_b_d = mem_dq_oe_b_o;

    case (st_q)
      S_IDLE: begin
        // requests while busy are dropped silently; callers wait for busy low
        if (req_i) begin
          addr_d = addr_i;
          busy_d = 1'b1;
          csend_d = cs_end_i;
          cnt_d = 4'h0;
          if (we_i) begin
            dq_d = wdata_i;
            st_d = S_WSEL;
          end else begin
            st_d = S_RSEL;
          end
        end
      end
      S_RSEL: begin
        // oe falls with cs; parts without oe simply ignore it
        // select falls
        cs_b_d = 1'b0;
        oe_b_d = 1'b0;
        we_b_d = 1'b1;
        cnt_d = 4'h0;
        st_d = S_RWAIT;
      end
      S_RWAIT: begin
        // full access wait, plus two sync stages
        if (cnt_q == AA_N + 4'h2) begin
          rdata_d = dq_sync;
          done_d = 1'b1;
          cs_b_d = 1'b1;
          oe_b_d = 1'b1;
          cnt_d = 4'h0;
          st_d = S_REC;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      S_WSEL: begin
        // strobe pulse is counted from here, so its first cycle is already one
        // both low together
        cs_b_d = 1'b0;
        we_b_d = 1'b0;
        oe_b_d = 1'b1;
        dq_oe_b_d = 1'b0;
        cnt_d = 4'h1;
        st_d = S_WPUL;
      end
      S_WPUL: begin
        // the ending edge was chosen with the request
        if (cnt_q >= WP_N) begin
          if (csend_q) begin
            cs_b_d = 1'b1;
          end else begin
            we_b_d = 1'b1;
          end
          cnt_d = 4'h0;
          done_d = 1'b1;
          st_d = S_REC;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      S_REC: begin
        // release the rest; data held one cycle past the end
        cs_b_d = 1'b1;
        we_b_d = 1'b1;
        dq_oe_b_d = 1'b1;
        // gap lets the memory float its pins before the next cycle
        if (cnt_q >= HZ_N) begin
          busy_d = 1'b0;
          st_d = S_IDLE;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // outputs come straight from these flops, so the pins never glitch
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      // reset keeps the memory deselected so nothing is written at power-up
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      csend_q <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= {DW{1'b0}};
      mem_addr_o <= {AW{1'b0}};
      mem_cs_b_o <= `ASR_PIN_IDLE;
      mem_we_b_o <= `ASR_PIN_IDLE;
      mem_oe_b_o <= `ASR_PIN_IDLE;
      mem_dq_o <= {DW{1'b0}};
      mem_dq_oe_b_o <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      csend_q <= csend_d;
      busy_o <= busy_d;
      done_o <= done_d;
      rdata_o <= rdata_d;
      mem_addr_o <= addr_d;
      mem_cs_b_o <= cs_b_d;
      mem_we_b_o <= we_b_d;
      mem_oe_b_o <= oe_b_d;
      mem_dq_o <= dq_d;
      mem_dq_oe_b_o <= dq_oe_b_d;
    end
  end

endmodule // asr_ctrl

// file: logic/asr_defines.vh
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH
// ****************************************
// timing in nanoseconds, slowest speed grade
// ****************************************
`define ASR_CLK_NS 50
`define ASR_T_AA_NS 35
`define ASR_T_WP_NS 30
`define ASR_T_DW_NS 15
`define ASR_T_HZ_NS 15
// least times round up to whole cycles, at least one
`define ASR_CEIL(x) (((x) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_MIN1(x) (((x) < 1) ? 1 : (x))
`define ASR_AA_CYC `ASR_MIN1(`ASR_CEIL(`ASR_T_AA_NS))
`define ASR_WP_CYC `ASR_MIN1(`ASR_CEIL(`ASR_T_WP_NS))
`define ASR_HZ_CYC `ASR_MIN1(`ASR_CEIL(`ASR_T_HZ_NS))
// ****************************************
// widths and reset values
// ****************************************
`define ASR_AW 12
`define ASR_DW 4
`define ASR_CNT_W 4
`define ASR_PIN_IDLE 1'b1
`endif

// file: logic/asr_sync.v
`timescale 1ns/1ps
`include "asr_defines.vh"
// two-flop synchroniser for the read data pins
module asr_sync #(
  parameter W = 4
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // asr_sync
